// File: rtl/wct_params.svh
// Constants of the weekly three-window switching timer
`ifndef WCT_PARAMS_SVH
`define WCT_PARAMS_SVH

// Register byte offsets
`define WCT_CTRL_OFS 8'h00
`define WCT_TIME_OFS 8'h04
`define WCT_STAT_OFS 8'h08
`define WCT_DAYS_OFS 8'h10
`define WCT_TIMES_OFS 8'h14
`define WCT_WIN_STRIDE 8
`define WCT_NUM_WIN 3

// Control fields
`define WCT_PULSE_BIT 0
`define WCT_EN_BIT 1
`define WCT_PULSE_RST 1'b0
`define WCT_EN_RST 1'b1

// Clock-time word fields
`define WCT_MIN_LSB 0
`define WCT_HOUR_LSB 8
`define WCT_WDAY_LSB 16

// Window time word fields
`define WCT_ON_MIN_LSB 0
`define WCT_ON_HOUR_LSB 8
`define WCT_ON_SET_BIT 15
`define WCT_OFF_MIN_LSB 16
`define WCT_OFF_HOUR_LSB 24
`define WCT_OFF_SET_BIT 31

// Ranges
`define WCT_MAX_MIN 6'd59
`define WCT_MAX_SEC 6'd59
`define WCT_MAX_HOUR 5'd23
`define WCT_MAX_WDAY 3'd6

// Timing
`define WCT_CLK_HZ 25000000
`define WCT_SEC_TIME_S 1
`define WCT_SEC_CYCLES (`WCT_CLK_HZ * `WCT_SEC_TIME_S)
`define WCT_EVAL_TIME_US 1000
`define WCT_EVAL_CYCLES ((`WCT_CLK_HZ / 1000000) * `WCT_EVAL_TIME_US)

`endif

// File: rtl/wct_pkg.sv
// Types shared by the weekly switching timer
package wct_pkg;
    typedef logic [31:0] wct_word_t; // Bus data word
    typedef logic [7:0] wct_addr_t; // Bus byte address
    typedef logic [6:0] wct_days_t; // One flag per weekday, bit 0 Monday
    typedef logic [5:0] wct_min_t; // Minute 0..59
    typedef logic [4:0] wct_hour_t; // Hour 0..23
    typedef logic [2:0] wct_wday_t; // Weekday 0 Monday .. 6 Sunday
endpackage

// File: rtl/wct_weekly_timer.sv
// Weekly three-window switching timer with its own clock and bus slave
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "wct_params.svh"

module wct_weekly_timer #(
    parameter int SEC_CYCLES = `WCT_SEC_CYCLES,
    parameter int EVAL_CYCLES = `WCT_EVAL_CYCLES,
    parameter int NUM_WIN = `WCT_NUM_WIN
) (
    input wire logic CLK,
    input wire logic RST,
    input wire wct_pkg::wct_addr_t AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire wct_pkg::wct_word_t AVS_WRITEDATA,
    output wct_pkg::wct_word_t AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic TIMER_OUT
);
    import wct_pkg::*;

    // True when the address hits the given register of window idx
    function automatic logic win_hit(input wct_addr_t addr, input wct_addr_t base,
                                     input int idx);
        win_hit = (addr == wct_addr_t'(base + wct_addr_t'(idx * `WCT_WIN_STRIDE)));
    endfunction

    // True when an hour and minute pair lies inside one day
    function automatic logic hm_ok(input wct_min_t m, input wct_hour_t h);
        hm_ok = (m <= `WCT_MAX_MIN) && (h <= `WCT_MAX_HOUR);
    endfunction

    // Bus handshake state
    logic wait_q; // Waitrequest, high while idle
    wct_word_t rdata_q; // Read data, caught one cycle ahead of the answer
    wct_word_t rd_mux; // Selected read value
    logic req; // Read or write present
    logic wr_go; // Write takes effect this edge

    // Control register
    logic pulse_q; // Shared pulse behaviour
    logic en_q; // Timer enable

    // Real-time clock
    logic [31:0] sec_cnt_q; // Clock cycles inside the current second
    wct_min_t sec_q; // Seconds 0..59
    wct_min_t min_q; // Minutes
    wct_hour_t hour_q; // Hours
    wct_wday_t wday_q; // Weekday
    logic sec_tick; // Last cycle of a second
    logic min_tick; // Last cycle of a minute
    logic hour_tick; // Last cycle of an hour
    logic day_tick; // Last cycle of a day
    logic time_wr; // Clock-time register written with a legal value

    // Evaluation cycle
    logic [31:0] eval_cnt_q; // Cycles since the last evaluation
    logic eval_q; // One-cycle evaluation strobe

    // Window settings and compare state
    wct_days_t days_q [NUM_WIN]; // Active weekdays of each window
    wct_word_t tim_q [NUM_WIN]; // On and off time of each window
    logic [NUM_WIN-1:0] on_now; // On-time matches now
    logic [NUM_WIN-1:0] off_now; // Off-time matches now
    logic [NUM_WIN-1:0] on_prev_q; // On match seen at the last evaluation
    logic [NUM_WIN-1:0] off_prev_q; // Off match seen at the last evaluation
    logic [NUM_WIN-1:0] on_edge; // Fresh on event
    logic [NUM_WIN-1:0] off_edge; // Fresh off event
    logic [NUM_WIN-1:0] day_ok; // Window active on today
    logic [NUM_WIN-1:0] src_q; // Windows whose on event last set the output

    // Output
    logic any_on; // Some window fires its on event
    logic any_off; // Some window fires its off event
    logic out_q; // Switching state
    logic out_d; // Next switching state

    // ---------------------------------------------------------------
    // Avalon slave: one wait cycle on every access
    // ---------------------------------------------------------------
    assign req = AVS_READ | AVS_WRITE;
    // The write lands at the edge where the master sees waitrequest low
    assign wr_go = AVS_WRITE & ~wait_q;

    // Waitrequest drops for one cycle after a request is seen
    always_ff @(posedge CLK) begin
        if (RST) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req & wait_q);
        end
    end

    // Read data caught while waitrequest is still high, so it stands at the answer edge
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_q <= 32'h0000_0000;
        end else if (AVS_READ && wait_q) begin
            rdata_q <= rd_mux;
        end
    end

    // Read selection; unmapped offsets read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (AVS_ADDRESS == `WCT_CTRL_OFS) begin
            rd_mux[`WCT_PULSE_BIT] = pulse_q;
            rd_mux[`WCT_EN_BIT] = en_q;
        end else if (AVS_ADDRESS == `WCT_TIME_OFS) begin
            rd_mux[`WCT_MIN_LSB +: 6] = min_q;
            rd_mux[`WCT_HOUR_LSB +: 5] = hour_q;
            rd_mux[`WCT_WDAY_LSB +: 3] = wday_q;
        end else if (AVS_ADDRESS == `WCT_STAT_OFS) begin
            // Status: output, setting windows, windows active today
            rd_mux[0] = out_q;
            rd_mux[4 +: NUM_WIN] = src_q;
            rd_mux[8 +: NUM_WIN] = day_ok;
        end else begin
            // Window registers repeat at a fixed stride, days word then times word
            for (int k = 0; k < NUM_WIN; k++) begin
                if (win_hit(AVS_ADDRESS, `WCT_DAYS_OFS, k)) begin
                    rd_mux[6:0] = days_q[k];
                end else if (win_hit(AVS_ADDRESS, `WCT_TIMES_OFS, k)) begin
                    rd_mux = tim_q[k];
                end
            end
        end
    end

    assign AVS_WAITREQUEST = wait_q;
    assign AVS_READDATA = rdata_q;

    // Bus handshake checks
    // The master holds its request until it sees waitrequest low, so one stall suffices
    bus_ack_a: assert property (@(posedge CLK) disable iff (RST)
        req && wait_q |=> !wait_q)
        else $error("waitrequest did not drop after a request");
    bus_rel_a: assert property (@(posedge CLK) disable iff (RST)
        !wait_q |=> wait_q)
        else $error("waitrequest stayed low for more than one cycle");

    // ---------------------------------------------------------------
    // Control register: one pulse setting for the whole timer
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            pulse_q <= `WCT_PULSE_RST;
            en_q <= `WCT_EN_RST;
        end else if (wr_go && AVS_ADDRESS == `WCT_CTRL_OFS) begin
            pulse_q <= AVS_WRITEDATA[`WCT_PULSE_BIT];
            en_q <= AVS_WRITEDATA[`WCT_EN_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Real-time clock
    // ---------------------------------------------------------------
    // A clock-time write with an out-of-range value is dropped whole
    assign time_wr = wr_go && (AVS_ADDRESS == `WCT_TIME_OFS)
        && hm_ok(AVS_WRITEDATA[`WCT_MIN_LSB +: 6], AVS_WRITEDATA[`WCT_HOUR_LSB +: 5])
        && (AVS_WRITEDATA[`WCT_WDAY_LSB +: 3] <= `WCT_MAX_WDAY);
    assign sec_tick = (sec_cnt_q == 32'(SEC_CYCLES - 1));
    assign min_tick = sec_tick && (sec_q == `WCT_MAX_SEC);
    assign hour_tick = min_tick && (min_q == `WCT_MAX_MIN);
    assign day_tick = hour_tick && (hour_q == `WCT_MAX_HOUR);

    // Sub-second counter; a time write restarts the second
    always_ff @(posedge CLK) begin
        if (RST || time_wr || sec_tick) begin
            sec_cnt_q <= 32'h0000_0000;
        end else begin
            sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
        end
    end

    // Seconds, minutes, hours and weekday roll over together
    always_ff @(posedge CLK) begin
        if (RST) begin
            sec_q <= 6'h00;
            min_q <= 6'h00;
            hour_q <= 5'h00;
            wday_q <= 3'h0;
        end else if (time_wr) begin
            sec_q <= 6'h00;
            min_q <= AVS_WRITEDATA[`WCT_MIN_LSB +: 6];
            hour_q <= AVS_WRITEDATA[`WCT_HOUR_LSB +: 5];
            wday_q <= AVS_WRITEDATA[`WCT_WDAY_LSB +: 3];
        end else if (sec_tick) begin
            sec_q <= min_tick ? 6'h00 : sec_q + 6'h01;
            if (min_tick) begin
                min_q <= hour_tick ? 6'h00 : min_q + 6'h01;
            end
            if (hour_tick) begin
                hour_q <= day_tick ? 5'h00 : hour_q + 5'h01;
            end
            if (day_tick) begin
                wday_q <= (wday_q == `WCT_MAX_WDAY) ? 3'h0 : wday_q + 3'h1;
            end
        end
    end

    // The time of day never leaves 00:00 .. 23:59
    time_rng_a: assert property (@(posedge CLK) disable iff (RST)
        hour_q <= `WCT_MAX_HOUR && min_q <= `WCT_MAX_MIN)
        else $error("clock time left the day range");

    // Seconds and weekday stay in range too, or the day flag index would run off
    wday_rng_a: assert property (@(posedge CLK) disable iff (RST)
        sec_q <= `WCT_MAX_SEC && wday_q <= `WCT_MAX_WDAY)
        else $error("seconds or weekday left their range");

    // ---------------------------------------------------------------
    // Evaluation cycle strobe
    // ---------------------------------------------------------------
    // All window compares and output changes happen only on this strobe
    always_ff @(posedge CLK) begin
        if (RST) begin
            eval_cnt_q <= 32'h0000_0000;
            eval_q <= 1'b0;
        end else begin
            eval_q <= (eval_cnt_q == 32'(EVAL_CYCLES - 1));
            if (eval_cnt_q == 32'(EVAL_CYCLES - 1)) begin
                eval_cnt_q <= 32'h0000_0000;
            end else begin
                eval_cnt_q <= eval_cnt_q + 32'h0000_0001;
            end
        end
    end

    // ---------------------------------------------------------------
    // Switching windows
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WIN; gi++) begin : g_win
            // Window settings; a time word with an illegal set time is dropped
            always_ff @(posedge CLK) begin
                if (RST) begin
                    days_q[gi] <= 7'h00;
                    tim_q[gi] <= 32'h0000_0000;
                end else if (wr_go && win_hit(AVS_ADDRESS, `WCT_DAYS_OFS, gi)) begin
                    days_q[gi] <= AVS_WRITEDATA[6:0];
                end else if (wr_go && win_hit(AVS_ADDRESS, `WCT_TIMES_OFS, gi)
                    && hm_ok(AVS_WRITEDATA[`WCT_ON_MIN_LSB +: 6],
                             AVS_WRITEDATA[`WCT_ON_HOUR_LSB +: 5])
                    && hm_ok(AVS_WRITEDATA[`WCT_OFF_MIN_LSB +: 6],
                             AVS_WRITEDATA[`WCT_OFF_HOUR_LSB +: 5])) begin
                    tim_q[gi] <= AVS_WRITEDATA;
                end
            end

            // Today's flag selects the window, one bit per weekday
            assign day_ok[gi] = days_q[gi][wday_q];

            // Unset times never match
            assign on_now[gi] = tim_q[gi][`WCT_ON_SET_BIT] && day_ok[gi]
                && (tim_q[gi][`WCT_ON_MIN_LSB +: 6] == min_q)
                && (tim_q[gi][`WCT_ON_HOUR_LSB +: 5] == hour_q);
            assign off_now[gi] = tim_q[gi][`WCT_OFF_SET_BIT] && day_ok[gi]
                && (tim_q[gi][`WCT_OFF_MIN_LSB +: 6] == min_q)
                && (tim_q[gi][`WCT_OFF_HOUR_LSB +: 5] == hour_q);

            // Only the first evaluation inside a matching minute counts
            assign on_edge[gi] = on_now[gi] & ~on_prev_q[gi];
            assign off_edge[gi] = off_now[gi] & ~off_prev_q[gi];

            // Match history, sampled once per evaluation cycle
            always_ff @(posedge CLK) begin
                if (RST) begin
                    on_prev_q[gi] <= 1'b0;
                    off_prev_q[gi] <= 1'b0;
                end else if (eval_q) begin
                    on_prev_q[gi] <= on_now[gi];
                    off_prev_q[gi] <= off_now[gi];
                end
            end

            // An on event needs the day flag and a set on-time
            day_gate_a: assert property (@(posedge CLK) disable iff (RST)
                on_edge[gi] |-> days_q[gi][wday_q] && tim_q[gi][`WCT_ON_SET_BIT])
                else $error("on event without day flag or set on-time");
            edge_once_a: assert property (@(posedge CLK) disable iff (RST)
                eval_q && on_now[gi] |=> !on_edge[gi])
                else $error("on match not recorded for the next evaluation");
        end
    endgenerate

    // ---------------------------------------------------------------
    // Combined output
    // ---------------------------------------------------------------
    // Any window can set or clear; with events taken in time order the earliest
    // on sets and the earliest later off clears, which resolves overlaps
    assign any_on = en_q && (|on_edge);
    assign any_off = en_q && (|off_edge);

    // Set wins over a clear in the same evaluation; pulse ends at the next one
    assign out_d = !eval_q ? out_q
        : !en_q ? 1'b0
        : any_on ? 1'b1
        : pulse_q ? 1'b0
        : any_off ? 1'b0
        : out_q;

    // Output and the record of which windows set it
    always_ff @(posedge CLK) begin
        if (RST) begin
            out_q <= 1'b0;
            src_q <= '0;
        end else begin
            out_q <= out_d;
            if (eval_q && any_on) begin
                src_q <= on_edge;
            end
        end
    end

    assign TIMER_OUT = out_q;

    // Output checks
    sequence s_on_eval;
        eval_q && en_q && (|on_edge);
    endsequence
    sequence s_pulse_end;
        eval_q && pulse_q && out_q && !(|on_edge);
    endsequence
    sequence s_off_eval;
        eval_q && en_q && !pulse_q && (|off_edge) && !(|on_edge);
    endsequence

    set_on_a: assert property (@(posedge CLK) disable iff (RST)
        s_on_eval |=> out_q)
        else $error("output not set by an on event");
    pulse_end_a: assert property (@(posedge CLK) disable iff (RST)
        s_pulse_end |=> !out_q)
        else $error("pulse lasted beyond one evaluation cycle");
    off_clr_a: assert property (@(posedge CLK) disable iff (RST)
        s_off_eval |=> !out_q)
        else $error("output not cleared by an off event");
    hold_out_a: assert property (@(posedge CLK) disable iff (RST)
        !eval_q |=> $stable(out_q))
        else $error("output changed outside an evaluation");

    // A disabled timer drops its output at the next evaluation
    en_clr_a: assert property (@(posedge CLK) disable iff (RST)
        eval_q && !en_q |=> !out_q)
        else $error("output not cleared while disabled");
endmodule

// File: tb/tb.sv
// Self-checking bench for the weekly three-window switching timer
`timescale 1ns/1ps
`include "wct_params.svh"

module tb;
    import wct_pkg::*;
    localparam int SEC = 8; // Short second, so one minute is 480 cycles
    localparam int EV = 4; // Short evaluation period, many per minute
    localparam int SETTLE = 2 * EV + 2; // Write lands, strobe comes, output edge follows
    logic clk = 1'b0; // 25 MHz system clock
    logic rst = 1'b1; // Synchronous reset, active high
    wct_addr_t adr = '0; // Bus address
    logic rd = 1'b0; // Bus read strobe
    logic wr = 1'b0; // Bus write strobe
    wct_word_t wdat = '0; // Bus write data
    wct_word_t rdat; // Bus read data
    logic wait_rq; // Slave stall
    logic tout; // Switching output
    int fails = 0;
    int checks_done = 0;
    wct_word_t got; // Last word read
    int wd, h, m, n; // Random day and time of a scenario, pulse length
    int oh[6] = '{1, 1, 1, 1, 1, 2}; // Overlap table: hours written
    int om[6] = '{0, 10, 20, 40, 50, 0}; // Overlap table: minutes written
    bit ox[6] = '{1, 1, 1, 0, 0, 0}; // Overlap table: expected output

    wct_weekly_timer #(.SEC_CYCLES(SEC), .EVAL_CYCLES(EV), .NUM_WIN(3)) wct_weekly_timer_i (
        .CLK(clk),
        .RST(rst),
        .AVS_ADDRESS(adr),
        .AVS_READ(rd),
        .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat),
        .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wait_rq),
        .TIMER_OUT(tout)
    );

    // Clock: 40 ns period
    always #20 clk = ~clk;

    // Closing report, the single place where the run ends
    task print_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Counts one comparison and reports a miss at once
    task bump(input bit ok, input string what);
        checks_done++;
        if (!ok) begin
            fails++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask

    // Compare a bus word
    task chk_word(input wct_word_t g, input wct_word_t e, input string what);
        bump(g === e, $sformatf("%s got %h exp %h", what, g, e));
    endtask

    // Compare the switching output as sampled at the last edge
    task chk_bit(input logic e, input string what);
        bump(tout === e, $sformatf("%s output %b exp %b", what, tout, e));
    endtask

    // One Avalon access; request held until waitrequest is seen low
    task bus(input logic is_wr, input wct_addr_t a, input wct_word_t d);
        int k;
        k = 0;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr <= is_wr;
        rd <= !is_wr;
        do begin
            @(posedge clk);
            k++;
        end while (wait_rq !== 1'b0 && k < 50);
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (k >= 50) begin
            bump(1'b0, "bus access never answered");
            print_verdict;
        end
    endtask

    // Read and compare one register
    task rd_chk(input wct_addr_t a, input wct_word_t e, input string what);
        bus(1'b0, a, '0);
        chk_word(got, e, what);
    endtask

    // Clock-time word
    function automatic wct_word_t tm(input int hh, input int mm, input int dd);
        return {13'h0, dd[2:0], 3'h0, hh[4:0], 2'h0, mm[5:0]};
    endfunction

    // Window time word: on half low, off half high
    function automatic wct_word_t tw(input int a, input int b, input int c, input int x,
                                     input int y, input int z);
        return {z[0], 2'h0, x[4:0], 2'h0, y[5:0], c[0], 2'h0, a[4:0], 2'h0, b[5:0]};
    endfunction

    // Program the days and times of one window
    task win(input int i, input wct_word_t days, input wct_word_t times);
        bus(1'b1, `WCT_DAYS_OFS + 8'(i * `WCT_WIN_STRIDE), days);
        bus(1'b1, `WCT_TIMES_OFS + 8'(i * `WCT_WIN_STRIDE), times);
    endtask

    // Park all windows with no active day, so no stray events arrive
    task clr;
        for (int i = 0; i < 3; i++) begin
            win(i, '0, '0);
        end
    endtask

    // Jump the clock, let one evaluation act, then look at the output
    task clk_chk(input int hh, input int mm, input int dd, input logic e, input string what);
        bus(1'b1, `WCT_TIME_OFS, tm(hh, mm, dd));
        repeat (SETTLE) @(posedge clk);
        chk_bit(e, what);
    endtask

    // Bounded wait for the output to reach a level
    task wait_out(input logic v, input int lim);
        int k;
        k = 0;
        while (tout !== v && k < lim) begin
            @(posedge clk);
            k++;
        end
        bump(tout === v, "output never reached level");
        if (tout !== v) begin
            print_verdict;
        end
    endtask

    // Main sequence
    initial begin
        void'($urandom(56023));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values and the unmapped hole
        rd_chk(`WCT_CTRL_OFS, 32'h0000_0002, "ctrl reset");
        rd_chk(`WCT_TIME_OFS, 32'h0000_0000, "time reset");
        rd_chk(`WCT_STAT_OFS, 32'h0000_0000, "status reset");
        for (int i = 0; i < 3; i++) begin
            rd_chk(`WCT_DAYS_OFS + 8'(i * 8), '0, "days reset");
            rd_chk(`WCT_TIMES_OFS + 8'(i * 8), '0, "times reset");
        end
        bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
        rd_chk(8'h0C, '0, "unmapped");
        $display("test reset done");
        // Random readback; set flags kept clear so nothing switches here
        for (int i = 0; i < 3; i++) begin
            wd = $urandom_range(127);
            h = $urandom_range(23);
            m = $urandom_range(59);
            win(i, 32'(wd), tw(h, m, 0, 23 - h, 59 - m, 0));
            rd_chk(`WCT_DAYS_OFS + 8'(i * 8), 32'(wd), "days");
            rd_chk(`WCT_TIMES_OFS + 8'(i * 8), tw(h, m, 0, 23 - h, 59 - m, 0),
                   "times");
        end
        // Window 2 holds the last random word, so the bad hour goes there
        bus(1'b1, `WCT_TIMES_OFS + 8'h10, tw(24, 0, 0, 0, 0, 0));
        rd_chk(`WCT_TIMES_OFS + 8'h10, tw(h, m, 0, 23 - h, 59 - m, 0),
               "bad hour kept out");
        bus(1'b1, `WCT_TIME_OFS, tm(23, 59, 6));
        bus(1'b1, `WCT_TIME_OFS, tm(23, 60, 6));
        bus(1'b1, `WCT_TIME_OFS, tm(1, 0, 7));
        rd_chk(`WCT_TIME_OFS, tm(23, 59, 6), "bad time kept out");
        clr;
        $display("test registers done");
        // Day gating, combined status, hold across day change, natural off
        wd = $urandom_range(6);
        h = $urandom_range(23);
        m = $urandom_range(58);
        win(0, 32'(7'h7F & ~(7'h01 << wd)), tw(h, m, 1, h, m + 1, 1));
        clk_chk(h, m, wd, 1'b0, "day not selected");
        bus(1'b1, `WCT_DAYS_OFS, 32'(7'h01 << wd));
        repeat (SETTLE) @(posedge clk);
        chk_bit(1'b1, "day selected");
        rd_chk(`WCT_STAT_OFS, 32'h0000_0111, "status");
        clk_chk(h, m, (wd + 1) % 7, 1'b1, "held on other day");
        bus(1'b1, `WCT_TIME_OFS, tm(h, m, wd));
        repeat (SEC * 50) @(posedge clk);
        chk_bit(1'b1, "held inside minute");
        wait_out(1'b0, SEC * 10 + 4 * EV + 20);
        rd_chk(`WCT_TIME_OFS, tm(h, m + 1, wd), "minute advanced");
        clr;
        $display("test gating done");
        // Unset times, then the enable gate
        win(1, 32'h0000_007F, tw(h, m, 0, h, m + 1, 0));
        clk_chk(h, m, wd, 1'b0, "unset on");
        win(1, 32'h0000_007F, tw(h, m, 1, h, m + 1, 0));
        clk_chk(h, m, wd, 1'b1, "on time");
        clk_chk(h, m + 1, wd, 1'b1, "unset off");
        bus(1'b1, `WCT_CTRL_OFS, 32'h0000_0000);
        repeat (SETTLE) @(posedge clk);
        chk_bit(1'b0, "disabled");
        bus(1'b1, `WCT_CTRL_OFS, 32'h0000_0002);
        clr;
        $display("test unset done");
        // Overlapping windows: earliest on and earliest off win
        win(0, 32'h0000_007F, tw(1, 0, 1, 2, 0, 1));
        win(1, 32'h0000_007F, tw(1, 10, 1, 1, 50, 1));
        win(2, 32'h0000_007F, tw(1, 20, 1, 1, 40, 1));
        for (int k = 0; k < 6; k++) begin
            clk_chk(oh[k], om[k], wd, ox[k], "overlap");
        end
        clr;
        $display("test overlap done");
        // Pulse mode, shared by windows 0 and 2, off-time ignored
        bus(1'b1, `WCT_CTRL_OFS, 32'h0000_0003);
        for (int k = 0; k < 3; k += 2) begin
            win(k, 32'h0000_007F, tw(5 + k, 0, 1, 5 + k, 0, 1));
            bus(1'b1, `WCT_TIME_OFS, tm(5 + k, 0, wd));
            wait_out(1'b1, SETTLE);
            n = 1;
            while (n < 20) begin
                @(posedge clk);
                if (tout !== 1'b1) break;
                n++;
            end
            chk_word(32'(n), 32'(EV), "pulse length");
            repeat (3 * EV) @(posedge clk);
            chk_bit(1'b0, "pulse over");
        end
        $display("test pulse done");
        print_verdict;
    end
endmodule
